// file: hsb_pkg.sv
package hsb_pkg;
   localparam int HSB_XLEN = 32;
   localparam int HSB_GPR_COUNT = 15;
   localparam logic [3:0] HSB_PC_INDEX = 4'hF;
   localparam logic [31:0] HSB_PC_BASE_AHEAD = 32'h0000_0008;
   localparam logic [31:0] HSB_PC_STORE_AHEAD = 32'h0000_000C;
   // Instruction field positions
   localparam int HSB_COND_MSB = 31;
   localparam int HSB_COND_LSB = 28;
   localparam int HSB_CLASS_MSB = 27;
   localparam int HSB_CLASS_LSB = 25;
   localparam int HSB_BIT_INDEX = 24;
   localparam int HSB_BIT_UP = 23;
   localparam int HSB_BIT_IMM = 22;
   localparam int HSB_BIT_WB = 21;
   localparam int HSB_BIT_LOAD = 20;
   localparam int HSB_BASE_LSB = 16;
   localparam int HSB_DEST_LSB = 12;
   localparam int HSB_IMM_HI_LSB = 8;
   localparam int HSB_BIT_MARK7 = 7;
   localparam int HSB_BIT_SIGN = 6;
   localparam int HSB_BIT_HALF = 5;
   localparam int HSB_BIT_MARK4 = 4;
   localparam int HSB_IDX_LSB = 0;
   localparam logic [2:0] HSB_CLASS_CODE = 3'h0;
   // Register port map (byte addresses, one word each)
   localparam logic [7:0] HSB_ADDR_GPR_LAST = 8'h38;
   localparam logic [7:0] HSB_ADDR_STATUS = 8'h3C;
   localparam logic [7:0] HSB_ADDR_CONTROL = 8'h40;
   localparam int HSB_ST_BUSY = 0;
   localparam int HSB_ST_ABORT = 1;
   localparam int HSB_ST_BYTE_ORDER_SELECT = 2;
   localparam int HSB_ST_CONDFAIL = 3;
   localparam int HSB_ST_ILLEGAL = 4;
   localparam int HSB_CTL_ENABLE = 0;
   localparam logic HSB_CTL_ENABLE_RESET = 1'b1;

   typedef enum logic [2:0] {
      HSB_IDLE = 3'b000,
      HSB_DATA = 3'b001,
      HSB_INTERNAL = 3'b010,
      HSB_REFILL_N = 3'b011,
      HSB_REFILL_S = 3'b100,
      HSB_FETCH_S = 3'b101,
      HSB_FETCH_N = 3'b110
   } hsb_state_e;

   typedef enum logic [1:0] {
      HSB_CYC_NONE = 2'b00,
      HSB_CYC_SEQ = 2'b01,
      HSB_CYC_NONSEQ = 2'b10,
      HSB_CYC_INTERNAL = 2'b11
   } hsb_cycle_e;

   typedef struct packed {
      logic [3:0] n_z_c_v;
   } hsb_flags_s;

   typedef struct packed {
      hsb_state_e state;
      logic [3:0] dest;
      logic [3:0] base;
      logic load;
      logic sgn;
      logic half;
      logic base_wb;
      logic [31:0] base_new;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic [31:0] load_val;
      logic [31:0] pc_target;
      logic pc_load;
      logic done;
      logic abort_pulse;
      logic enable;
      logic abort_flag;
      logic cond_fail;
      logic illegal;
      logic order_s1;
      logic order_s2;
      logic [31:0] reg_rdata;
      logic [HSB_GPR_COUNT-1:0][31:0] gpr;
   } hsb_core_s;
endpackage : hsb_pkg

// file: hsb_transfer.sv
`timescale 1ns/1ps
module hsb_transfer
   import hsb_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [31:0] instr_in,
   input wire logic instr_valid_in,
   output logic instr_ready_out,
   input wire logic [31:0] instr_addr_in,
   input wire hsb_flags_s flags_in,
   input wire logic byte_order_select_in,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   output logic mem_req_out,
   output logic mem_write_out,
   output logic mem_half_out,
   output logic [1:0] cycle_type_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_abort_in,
   output logic done_out,
   output logic data_abort_out,
   output logic [31:0] pc_target_out,
   output logic pc_load_out,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out
);

   if (HSB_XLEN != 32 || HSB_GPR_COUNT != 15) begin : g_size_check
      $error("hsb_transfer serves a 32-bit core with 15 general registers only");
   end

   hsb_core_s q;
   hsb_core_s d;

   function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      logic r;
      n = f[3];
      z = f[2];
      cy = f[1];
      v = f[0];
      unique case (c[3:1])
         3'h0: r = z;
         3'h1: r = cy;
         3'h2: r = n;
         3'h3: r = v;
         3'h4: r = cy & ~z;
         3'h5: r = (n == v);
         3'h6: r = ~z & (n == v);
         3'h7: r = 1'b1;
      endcase
      // Odd codes invert, except the always code 4'hF which stays true
      if (c[0] && c[3:1] != 3'h7) begin
         r = ~r;
      end
      return r;
   endfunction : cond_pass

   function automatic logic [31:0] read_gpr(input logic [HSB_GPR_COUNT-1:0][31:0] g,
                                           input logic [3:0] idx,
                                           input logic [31:0] pc_view);
      logic [31:0] r;
      if (idx == HSB_PC_INDEX) begin
         r = pc_view;
      end else begin
         r = g[idx];
      end
      return r;
   endfunction : read_gpr

   // Register words fill the port map at four-byte steps below the status word
   function automatic logic gpr_slot(input logic [7:0] a);
      return (a <= HSB_ADDR_GPR_LAST) && (a[1:0] == 2'b00);
   endfunction : gpr_slot

   // Lane picking and extension of load data
   function automatic logic [31:0] load_extract(input logic [31:0] bus,
                                                input logic [1:0] a,
                                                input logic big,
                                                input logic sgn,
                                                input logic half);
      logic [1:0] lane;
      logic [7:0] b;
      logic [15:0] h;
      logic [31:0] r;
      lane = big ? (2'h3 - a) : a;
      b = 8'(bus >> {lane, 3'b000});
      if (big) begin
         h = a[1] ? bus[15:0] : bus[31:16];
      end else begin
         h = a[1] ? bus[31:16] : bus[15:0];
      end
      if (!half) begin
         r = {{24{b[7]}}, b};
      end else if (sgn) begin
         r = {{16{h[15]}}, h};
      end else begin
         r = {16'h0000, h};
      end
      return r;
   endfunction : load_extract

   logic [3:0] f_cond;
   logic [3:0] f_base;
   logic [3:0] f_dest;
   logic [3:0] f_idx;
   logic f_pre;
   logic f_up;
   logic f_imm;
   logic f_wb;
   logic f_load;
   logic f_sgn;
   logic f_half;
   logic f_legal;
   logic [31:0] base_val;
   logic [31:0] offset;
   logic [31:0] moved;
   logic [31:0] src_val;
   logic issue;

   always_comb begin
      f_cond = instr_in[HSB_COND_MSB:HSB_COND_LSB];
      f_pre = instr_in[HSB_BIT_INDEX];
      f_up = instr_in[HSB_BIT_UP];
      f_imm = instr_in[HSB_BIT_IMM];
      f_wb = instr_in[HSB_BIT_WB];
      f_load = instr_in[HSB_BIT_LOAD];
      f_base = instr_in[HSB_BASE_LSB+:4];
      f_dest = instr_in[HSB_DEST_LSB+:4];
      f_idx = instr_in[HSB_IDX_LSB+:4];
      f_sgn = instr_in[HSB_BIT_SIGN];
      f_half = instr_in[HSB_BIT_HALF];
      // Pick code 00 belongs to the swap class and is not served here
      f_legal = (instr_in[HSB_CLASS_MSB:HSB_CLASS_LSB] == HSB_CLASS_CODE)
                && instr_in[HSB_BIT_MARK7] && instr_in[HSB_BIT_MARK4]
                && (f_sgn || f_half);
      base_val = read_gpr(q.gpr, f_base, instr_addr_in + HSB_PC_BASE_AHEAD);
      if (f_imm) begin
         offset = {24'h000000, instr_in[HSB_IMM_HI_LSB+:4], instr_in[HSB_IDX_LSB+:4]};
      end else begin
         offset = read_gpr(q.gpr, f_idx, instr_addr_in + HSB_PC_BASE_AHEAD);
      end
      moved = f_up ? (base_val + offset) : (base_val - offset);
      src_val = read_gpr(q.gpr, f_dest, instr_addr_in + HSB_PC_STORE_AHEAD);
      issue = instr_valid_in && instr_ready_out;
   end

   assign instr_ready_out = (q.state == HSB_IDLE) && q.enable;

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.abort_pulse = 1'b0;
      d.pc_load = 1'b0;
      d.order_s1 = byte_order_select_in;
      d.order_s2 = q.order_s1;
      d.reg_rdata = 32'h0000_0000;

      // Register port: software access to the register file and status
      if (reg_write_in) begin
         if (gpr_slot(reg_addr_in)) begin
            d.gpr[reg_addr_in[5:2]] = reg_wdata_in;
         end else if (reg_addr_in == HSB_ADDR_CONTROL) begin
            d.enable = reg_wdata_in[HSB_CTL_ENABLE];
         end else if (reg_addr_in == HSB_ADDR_STATUS) begin
            if (reg_wdata_in[HSB_ST_ABORT]) begin
               d.abort_flag = 1'b0;
            end
            if (reg_wdata_in[HSB_ST_CONDFAIL]) begin
               d.cond_fail = 1'b0;
            end
            if (reg_wdata_in[HSB_ST_ILLEGAL]) begin
               d.illegal = 1'b0;
            end
         end
      end
      if (reg_read_in) begin
         if (gpr_slot(reg_addr_in)) begin
            d.reg_rdata = q.gpr[reg_addr_in[5:2]];
         end else if (reg_addr_in == HSB_ADDR_CONTROL) begin
            d.reg_rdata[HSB_CTL_ENABLE] = q.enable;
         end else if (reg_addr_in == HSB_ADDR_STATUS) begin
            d.reg_rdata[HSB_ST_BUSY] = (q.state != HSB_IDLE);
            d.reg_rdata[HSB_ST_ABORT] = q.abort_flag;
            d.reg_rdata[HSB_ST_BYTE_ORDER_SELECT] = q.order_s2;
            d.reg_rdata[HSB_ST_CONDFAIL] = q.cond_fail;
            d.reg_rdata[HSB_ST_ILLEGAL] = q.illegal;
         end
      end

      // Execution writes come after the port, so they win on a clash
      unique case (q.state)
         HSB_IDLE: begin
            if (issue) begin
               if (!f_legal) begin
                  d.illegal = 1'b1;
                  d.state = HSB_FETCH_S;
               end else if (!cond_pass(f_cond, flags_in.n_z_c_v)) begin
                  d.cond_fail = 1'b1;
                  d.state = HSB_FETCH_S;
               end else begin
                  d.dest = f_dest;
                  d.base = f_base;
                  d.load = f_load;
                  d.sgn = f_sgn;
                  d.half = f_half;
                  d.mem_addr = f_pre ? moved : base_val;
                  d.base_new = moved;
                  // Post-indexed always writes back; a program-counter base is never written
                  d.base_wb = (f_pre ? f_wb : 1'b1) && (f_base != HSB_PC_INDEX);
                  d.mem_wdata = {src_val[15:0], src_val[15:0]};
                  d.state = HSB_DATA;
               end
            end
         end
         HSB_DATA: begin
            if (mem_abort_in) begin
               // Nothing is committed, so software can restart the instruction
               d.abort_flag = 1'b1;
               d.abort_pulse = 1'b1;
               d.state = HSB_IDLE;
            end else begin
               if (q.base_wb) begin
                  d.gpr[q.base] = q.base_new;
               end
               d.load_val = load_extract(mem_rdata_in, q.mem_addr[1:0], q.order_s2,
                                         q.sgn, q.half);
               d.state = q.load ? HSB_INTERNAL : HSB_FETCH_N;
            end
         end
         HSB_INTERNAL: begin
            if (q.dest == HSB_PC_INDEX) begin
               d.pc_target = q.load_val;
               d.pc_load = 1'b1;
               d.state = HSB_REFILL_N;
            end else begin
               d.gpr[q.dest] = q.load_val;
               d.state = HSB_FETCH_S;
            end
         end
         HSB_REFILL_N: begin
            d.state = HSB_REFILL_S;
         end
         HSB_REFILL_S: begin
            d.state = HSB_FETCH_S;
         end
         HSB_FETCH_S: begin
            d.state = HSB_IDLE;
         end
         HSB_FETCH_N: begin
            d.state = HSB_IDLE;
         end
         default: begin
            d.state = HSB_IDLE;
         end
      endcase
      // Done rides with the closing fetch cycle, so the issuer sees it beside that cycle
      d.done = (d.state == HSB_FETCH_S) || (d.state == HSB_FETCH_N);
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
         q.state <= HSB_IDLE;
         q.enable <= HSB_CTL_ENABLE_RESET;
      end else begin
         q <= d;
      end
   end

   // Bus strobes follow the registered state; address and data are flops
   always_comb begin
      unique case (q.state)
         HSB_DATA: cycle_type_out = HSB_CYC_NONSEQ;
         HSB_INTERNAL: cycle_type_out = HSB_CYC_INTERNAL;
         HSB_REFILL_N: cycle_type_out = HSB_CYC_NONSEQ;
         HSB_FETCH_N: cycle_type_out = HSB_CYC_NONSEQ;
         HSB_REFILL_S: cycle_type_out = HSB_CYC_SEQ;
         HSB_FETCH_S: cycle_type_out = HSB_CYC_SEQ;
         default: cycle_type_out = HSB_CYC_NONE;
      endcase
   end

   assign mem_req_out = (q.state == HSB_DATA);
   assign mem_write_out = (q.state == HSB_DATA) && !q.load;
   assign mem_half_out = q.half;
   assign mem_addr_out = q.mem_addr;
   assign mem_wdata_out = q.mem_wdata;
   assign done_out = q.done;
   assign data_abort_out = q.abort_pulse;
   assign pc_target_out = q.pc_target;
   assign pc_load_out = q.pc_load;
   assign reg_rdata_out = q.reg_rdata;

endmodule : hsb_transfer

// file: hsb_mem_model.sv
`timescale 1ns/1ps
module hsb_mem_model
   import hsb_pkg::*;
(
   input wire logic clk_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic req_in,
   input wire logic write_in,
   input wire logic big_in,
   input wire logic abort_en_in,
   output logic [31:0] rdata_out,
   output logic abort_out
);
   logic [31:0] mem_q [16];
   logic [3:0] idx;
   logic upper;
   assign idx = addr_in[5:2];
   assign upper = addr_in[1] ^ big_in;
   // Idle bus shows the inverse, so a sample taken outside the data cycle cannot match
   assign rdata_out = (req_in && !write_in) ? mem_q[idx] : ~mem_q[idx];
   assign abort_out = req_in && abort_en_in;
   always @(posedge clk_in) begin
      if (req_in && write_in && upper) begin
         mem_q[idx][31:16] <= wdata_in[31:16];
      end
      if (req_in && write_in && !upper) begin
         mem_q[idx][15:0] <= wdata_in[15:0];
      end
   end
endmodule : hsb_mem_model

// file: hsb_transfer_checker.sv
`timescale 1ns/1ps
module hsb_transfer_checker
   import hsb_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [31:0] instr_in,
   input wire logic instr_valid_in,
   input wire logic instr_ready_out,
   input wire hsb_flags_s flags_in,
   input wire logic mem_req_out,
   input wire logic mem_write_out,
   input wire logic mem_half_out,
   input wire logic [1:0] cycle_type_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic mem_abort_in,
   input wire logic done_out,
   input wire logic data_abort_out,
   input wire logic pc_load_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   logic take;
   logic legal;
   assign take = instr_valid_in && instr_ready_out;
   assign legal = instr_in[31:28] == 4'hE && instr_in[27:25] == 3'h0;
   sequence load_ok; mem_req_out && !mem_write_out && !mem_abort_in; endsequence
   sequence store_ok; mem_req_out && mem_write_out && !mem_abort_in; endsequence
   sequence tail_plain; cycle_type_out == 2'h1 && done_out; endsequence
   sequence tail_store; cycle_type_out == 2'h2 && done_out; endsequence
   sequence tail_pc;
      cycle_type_out == 2'h2 && pc_load_out ##1 cycle_type_out == 2'h1 && !done_out ##1 tail_plain;
   endsequence
   AST_LOAD_INTERNAL: assert property (load_ok |=> cycle_type_out == 2'h3 && !mem_req_out)
      else $error("load lacks internal cycle");
   AST_LOAD_FINISH: assert property (load_ok |=> ##1 (tail_plain or tail_pc))
      else $error("load cycle sequence wrong");
   AST_STORE_TWO_N: assert property (store_ok |-> cycle_type_out == 2'h2 ##1 tail_store)
      else $error("store not two N cycles");
   AST_STORE_COPY: assert property (store_ok |-> mem_wdata_out[31:16] == mem_wdata_out[15:0])
      else $error("store halves differ");
   AST_ABORT_TRAP: assert property (mem_req_out && mem_abort_in |=> data_abort_out && !done_out ##1 !done_out)
      else $error("abort not trapped");
   AST_COND_SKIP: assert property (take && instr_in[31:28] == 4'h0 && !flags_in.n_z_c_v[2] |=> done_out && !mem_req_out)
      else $error("failed condition executed");
   AST_COND_RUN: assert property (take && legal && instr_in[7] && instr_in[4] && instr_in[5] |=> mem_req_out)
      else $error("passing instruction not run");
   AST_BYTE_SIZE: assert property (take && legal && instr_in[7:4] == 4'hD |=> mem_req_out && !mem_half_out)
      else $error("byte load sized wrong");
   AST_HALF_SIZE: assert property (take && legal && instr_in[7:4] == 4'hB |=> mem_req_out && mem_half_out)
      else $error("half transfer sized wrong");
endmodule : hsb_transfer_checker
bind hsb_transfer hsb_transfer_checker hsb_transfer_checker_inst (.clk_in, .reset_n_in, .instr_in,
   .instr_valid_in, .instr_ready_out, .flags_in, .mem_req_out, .mem_write_out, .mem_half_out,
   .cycle_type_out, .mem_wdata_out, .mem_abort_in, .done_out, .data_abort_out, .pc_load_out);

// file: tb.sv
`timescale 1ns/1ps
module tb
   import hsb_pkg::*;
   ;
   typedef struct packed {
      logic big;
      logic [31:0] instr;
      logic [31:0] dest;
      logic [31:0] base;
      logic [3:0] cyc;
   } hsb_row_s;
   localparam hsb_row_s ROWS [11] = '{
      '{1'b0, 32'hE1D120B2, 32'h00008A7B, 32'h00000100, 4'h3},
      '{1'b0, 32'hE1D120D1, 32'hFFFFFFC6, 32'h00000100, 4'h3},
      '{1'b0, 32'hE1D120D3, 32'hFFFFFF8A, 32'h00000100, 4'h3},
      '{1'b0, 32'hE17120F4, 32'hFFFFF00D, 32'h000000FC, 4'h3},
      '{1'b0, 32'hE0D121B3, 32'h0000C6D5, 32'h00000113, 4'h3},
      '{1'b0, 32'hE19120B3, 32'h00008A7B, 32'h00000100, 4'h3},
      '{1'b1, 32'hE1D120D1, 32'h0000007B, 32'h00000100, 4'h3},
      '{1'b1, 32'hE1D120D3, 32'hFFFFFFD5, 32'h00000100, 4'h3},
      '{1'b1, 32'hE1D120B2, 32'h0000C6D5, 32'h00000100, 4'h3},
      '{1'b1, 32'hE1D120F0, 32'hFFFF8A7B, 32'h00000100, 4'h3},
      '{1'b0, 32'h019120B3, 32'h55555555, 32'h00000100, 4'h1}};
   logic clk_in, reset_n_in, instr_valid_in, instr_ready_out, byte_order_select_in;
   logic mem_req_out, mem_write_out, mem_half_out, mem_abort_in, done_out, data_abort_out;
   logic pc_load_out, reg_write_in, reg_read_in, abort_en;
   logic [31:0] instr_in, instr_addr_in, mem_addr_out, mem_wdata_out, mem_rdata_in;
   logic [31:0] pc_target_out, reg_wdata_in, reg_rdata_out, v, n, pt;
   logic [7:0] reg_addr_in;
   logic [1:0] cycle_type_out;
   hsb_flags_s flags_in;
   int failures, tests_run;
   hsb_transfer hsb_transfer_inst (.clk_in, .reset_n_in, .instr_in, .instr_valid_in,
      .instr_ready_out, .instr_addr_in, .flags_in, .byte_order_select_in, .mem_addr_out,
      .mem_wdata_out, .mem_req_out, .mem_write_out, .mem_half_out, .cycle_type_out,
      .mem_rdata_in, .mem_abort_in, .done_out, .data_abort_out, .pc_target_out, .pc_load_out,
      .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out);
   hsb_mem_model hsb_mem_model_inst (.clk_in(clk_in), .addr_in(mem_addr_out),
      .wdata_in(mem_wdata_out), .req_in(mem_req_out), .write_in(mem_write_out),
      .big_in(byte_order_select_in), .abort_en_in(abort_en), .rdata_out(mem_rdata_in),
      .abort_out(mem_abort_in));
   always #25 clk_in = ~clk_in;
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clk_in);
      reg_write_in <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clk_in);
      reg_read_in <= 1'b0;
      @(negedge clk_in);
      v = reg_rdata_out;
   endtask : reg_rd
   task automatic setup(input logic big, input logic [31:0] r2);
      byte_order_select_in <= big;
      reg_wr(8'h04, 32'h00000100);
      reg_wr(8'h08, r2);
      reg_wr(8'h0C, 32'h00000002);
   endtask : setup
   // Counts cycles from the taking edge to done or abort, bounded
   task automatic issue(input logic [31:0] ins);
      pt = '0;
      n = '0;
      @(posedge clk_in);
      instr_in <= ins;
      instr_addr_in <= 32'h00000200;
      instr_valid_in <= 1'b1;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      do begin
         @(negedge clk_in);
         n++;
         if (pc_load_out === 1'b1) begin
            pt = pc_target_out;
         end
      end while (n < 20 && done_out !== 1'b1 && data_abort_out !== 1'b1);
      if (n == 20) begin
         failures++;
         complete_run();
      end
   endtask : issue
   initial begin
      {clk_in, reset_n_in, instr_valid_in, byte_order_select_in, reg_write_in} = '0;
      {reg_read_in, abort_en, instr_in, instr_addr_in, reg_wdata_in, reg_addr_in} = '0;
      flags_in = '0;
      hsb_mem_model_inst.mem_q[0] = 32'h8A7BC6D5;
      hsb_mem_model_inst.mem_q[2] = 32'h9ABC0000;
      hsb_mem_model_inst.mem_q[15] = 32'h1234F00D;
      repeat (5) @(posedge clk_in);
      check("ready", {31'h0, instr_ready_out}, 32'h1);
      check("done", {31'h0, done_out}, 32'h0);
      reset_n_in <= 1'b1;
      foreach (ROWS[i]) begin
         setup(ROWS[i].big, 32'h55555555);
         issue(ROWS[i].instr);
         check("cycles", n, {28'h0, ROWS[i].cyc});
         reg_rd(8'h08);
         check("dest", v, ROWS[i].dest);
         reg_rd(8'h04);
         check("base", v, ROWS[i].base);
         $display("row %0d finished", i);
      end
      setup(1'b0, 32'h55555555);
      issue(32'hE1DF20B2);
      check("addr", mem_addr_out, 32'h0000020A);
      reg_rd(8'h08);
      check("dest", v, 32'h00009ABC);
      issue(32'hE1D1F0B2);
      check("cycles", n, 32'h5);
      check("pc", pt, 32'h00008A7B);
      $display("program counter test finished");
      abort_en <= 1'b1;
      issue(32'hE1F120B2);
      abort_en <= 1'b0;
      check("cycles", n, 32'h2);
      check("abort", {31'h0, data_abort_out}, 32'h1);
      reg_rd(8'h08);
      check("dest", v, 32'h00009ABC);
      reg_rd(8'h04);
      check("base", v, 32'h00000100);
      $display("abort test finished");
      setup(1'b0, 32'h0000ABCD);
      issue(32'hE1C120B2);
      check("cycles", n, 32'h2);
      check("wdata", mem_wdata_out, 32'hABCDABCD);
      check("mem", hsb_mem_model_inst.mem_q[0], 32'hABCDC6D5);
      issue(32'hE1C1F0B2);
      check("wdata", mem_wdata_out, 32'h020C020C);
      $display("store test finished");
      reg_wr(HSB_ADDR_CONTROL, 32'h0);
      @(negedge clk_in);
      check("ready", {31'h0, instr_ready_out}, 32'h0);
      reg_wr(HSB_ADDR_CONTROL, 32'h1);
      reg_rd(8'h80);
      check("unmapped", v, 32'h0);
      $display("register port test finished");
      issue(32'hE1D12092);
      check("cycles", n, 32'h1);
      reg_rd(HSB_ADDR_STATUS);
      check("status", v, 32'h0000001A);
      reg_wr(HSB_ADDR_STATUS, 32'h0000001A);
      reg_rd(HSB_ADDR_STATUS);
      check("status", v, 32'h0);
      $display("status test finished");
      reg_wr(HSB_ADDR_CONTROL, 32'h0);
      reset_n_in <= 1'b0;
      @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(negedge clk_in);
      check("ready", {31'h0, instr_ready_out}, 32'h1);
      reg_rd(8'h08);
      check("dest", v, 32'h0);
      $display("reset test finished");
      complete_run();
   end
endmodule : tb
